/* design/adc_port_pkg.sv */
package adc_port_pkg;

    // ========================================================
    // word and stage geometry
    // ========================================================
    localparam int WORD_W       = 10;
    localparam int STAGE_COUNT  = 10;
    localparam int ANALOG_W     = 12;
    localparam int RESIDUE_W    = 14;
    localparam int ACC_W        = 12;
    localparam int FIFO_DEPTH   = 4;

    // sample to output, in half periods of the conversion clock
    localparam int LATENCY_HALF = 11;

    // ========================================================
    // residue scaling
    // ========================================================
    localparam logic signed [RESIDUE_W-1:0] FULL_SCALE = 14'sh0800;
    localparam logic signed [RESIDUE_W-1:0] CMP_HIGH   = 14'sh0200;
    localparam logic signed [RESIDUE_W-1:0] CMP_LOW    = -14'sh0200;

    // offset binary coding
    localparam logic [WORD_W-1:0] CODE_MID    = 10'h200;
    localparam logic [WORD_W-1:0] CODE_TOP    = 10'h3FF;
    localparam logic [WORD_W-1:0] CODE_BOTTOM = 10'h000;
    localparam logic signed [ACC_W:0] ACC_HIGH = 13'sh01FF;
    localparam logic signed [ACC_W:0] ACC_LOW  = -13'sh0200;
    localparam int CORR_SHIFT = 1;

    // ========================================================
    // carriers
    // ========================================================
    typedef struct packed {
        logic                         valid;
        logic signed [RESIDUE_W-1:0]  residue;
        logic signed [ACC_W-1:0]      acc;
    } stage_payload_t;

    typedef enum logic [1:0] {
        DIGIT_ZERO,
        DIGIT_PLUS,
        DIGIT_MINUS
    } stage_digit_t;

    typedef enum logic {
        CONVERTING,
        SLEEPING
    } power_state_t;

endpackage : adc_port_pkg

/* design/conversion_stage.sv */
`timescale 1ns/1ps
module conversion_stage (
    // clock and reset
    input  wire logic                        core_clk,
    input  wire logic                        rst,
    // pipeline movement
    input  wire logic                        advance,
    input  wire adc_port_pkg::stage_payload_t stageIn,
    output adc_port_pkg::stage_payload_t     stageOut
);

    // ========================================================
    // two-comparator coarse decision
    // ========================================================
    adc_port_pkg::stage_digit_t   digit;
    adc_port_pkg::stage_payload_t stage_d;
    adc_port_pkg::stage_payload_t stage_q;
    logic signed [adc_port_pkg::RESIDUE_W-1:0] doubled;

    always_comb begin
        if (stageIn.residue > adc_port_pkg::CMP_HIGH) begin
            digit = adc_port_pkg::DIGIT_PLUS;
        end else if (stageIn.residue < adc_port_pkg::CMP_LOW) begin
            digit = adc_port_pkg::DIGIT_MINUS;
        end else begin
            digit = adc_port_pkg::DIGIT_ZERO;
        end
        doubled = stageIn.residue <<< 1;
        stage_d = stage_q;
        if (advance) begin
            stage_d.valid = stageIn.valid;
            unique case (digit)
                adc_port_pkg::DIGIT_PLUS: begin
                    stage_d.residue = doubled - adc_port_pkg::FULL_SCALE;
                    stage_d.acc     = (stageIn.acc <<< 1) + 12'sh001;
                end
                adc_port_pkg::DIGIT_MINUS: begin
                    stage_d.residue = doubled + adc_port_pkg::FULL_SCALE;
                    stage_d.acc     = (stageIn.acc <<< 1) - 12'sh001;
                end
                adc_port_pkg::DIGIT_ZERO: begin
                    stage_d.residue = doubled;
                    stage_d.acc     = stageIn.acc <<< 1;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            stage_q <= '0;
        end else begin
            stage_q <= stage_d;
        end
    end

    assign stageOut = stage_q;

endmodule : conversion_stage

/* design/sample_fifo.sv */
`timescale 1ns/1ps
module sample_fifo #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 4
) (
    // clock and reset
    input  wire logic             core_clk,
    input  wire logic             rst,
    // fill side
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    // drain side
    output logic                  outValid,
    input  wire logic             outReady,
    output logic [WIDTH-1:0]      outData
);

    localparam int PTR_W = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PTR_W-1:0] wrPtr_q;
    logic [PTR_W-1:0] wrPtr_d;
    logic [PTR_W-1:0] rdPtr_q;
    logic [PTR_W-1:0] rdPtr_d;
    logic [PTR_W:0]   count_q;
    logic [PTR_W:0]   count_d;
    logic             push;
    logic             pop;

    // ========================================================
    // pointers and occupancy
    // ========================================================
    assign inReady  = (count_q != (PTR_W+1)'(DEPTH));
    assign outValid = (count_q != '0);
    assign outData  = mem[rdPtr_q];
    assign push     = inValid && inReady;
    assign pop      = outValid && outReady;

    always_comb begin
        wrPtr_d = wrPtr_q;
        rdPtr_d = rdPtr_q;
        count_d = count_q;
        if (push) begin
            wrPtr_d = (wrPtr_q == PTR_W'(DEPTH-1)) ? '0 : wrPtr_q + 1'b1;
        end
        if (pop) begin
            rdPtr_d = (rdPtr_q == PTR_W'(DEPTH-1)) ? '0 : rdPtr_q + 1'b1;
        end
        if (push && !pop) begin
            count_d = count_q + 1'b1;
        end else if (pop && !push) begin
            count_d = count_q - 1'b1;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
            count_q <= '0;
        end else begin
            wrPtr_q <= wrPtr_d;
            rdPtr_q <= rdPtr_d;
            count_q <= count_d;
        end
    end

    // ========================================================
    // storage
    // ========================================================
    always_ff @(posedge core_clk) begin
        if (push) begin
            mem[wrPtr_q] <= inData;
        end
    end

endmodule : sample_fifo

/* design/pipelined_adc_output_port.sv */
`timescale 1ns/1ps
module pipelined_adc_output_port #(
    parameter int WORD_W  = adc_port_pkg::WORD_W,
    parameter int STAGES  = adc_port_pkg::STAGE_COUNT,
    parameter int FIFO_D  = adc_port_pkg::FIFO_DEPTH
) (
    // clock and reset
    input  wire logic                                   core_clk,
    input  wire logic                                   rst,
    // conversion pins
    input  wire logic                                   convClk,
    input  wire logic signed [adc_port_pkg::ANALOG_W-1:0] heldInput,
    input  wire logic                                   sleepRequest,
    input  wire logic                                   outEnableN,
    // sample word pins
    output logic [WORD_W-1:0]                           sampleWordOut,
    output logic                                        sampleWordOe
);

    // ========================================================
    // pin synchronisers
    // ========================================================
    logic                                     clkMeta_q;
    logic                                     clkSync_q;
    logic                                     clkPrev_q;
    logic                                     sleepMeta_q;
    logic                                     sleepSync_q;
    logic                                     oeMeta_q;
    logic                                     oeSync_q;
    logic signed [adc_port_pkg::ANALOG_W-1:0] inMeta_q;
    logic signed [adc_port_pkg::ANALOG_W-1:0] inSync_q;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            clkMeta_q   <= 1'b0;
            clkSync_q   <= 1'b0;
            clkPrev_q   <= 1'b0;
            sleepMeta_q <= 1'b1;
            sleepSync_q <= 1'b1;
            oeMeta_q    <= 1'b1;
            oeSync_q    <= 1'b1;
            inMeta_q    <= '0;
            inSync_q    <= '0;
        end else begin
            clkMeta_q   <= convClk;
            clkSync_q   <= clkMeta_q;
            clkPrev_q   <= clkSync_q;
            sleepMeta_q <= sleepRequest;
            sleepSync_q <= sleepMeta_q;
            oeMeta_q    <= outEnableN;
            oeSync_q    <= oeMeta_q;
            inMeta_q    <= heldInput;
            inSync_q    <= inMeta_q;
        end
    end

    logic riseEdge;
    logic fallEdge;
    logic anyEdge;

    assign riseEdge = clkSync_q && !clkPrev_q;
    assign fallEdge = !clkSync_q && clkPrev_q;
    assign anyEdge  = riseEdge || fallEdge;

    // ========================================================
    // power state
    // ========================================================
    adc_port_pkg::power_state_t power_q;
    adc_port_pkg::power_state_t power_d;

    always_comb begin
        power_d = power_q;
        unique case (power_q)
            adc_port_pkg::CONVERTING: begin
                if (sleepSync_q) begin
                    power_d = adc_port_pkg::SLEEPING;
                end
            end
            adc_port_pkg::SLEEPING: begin
                if (!sleepSync_q) begin
                    power_d = adc_port_pkg::CONVERTING;
                end
            end
        endcase
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            power_q <= adc_port_pkg::SLEEPING;
        end else begin
            power_q <= power_d;
        end
    end

    logic asleep;
    assign asleep = (power_q == adc_port_pkg::SLEEPING);

    // ========================================================
    // conversion pipeline
    // ========================================================
    adc_port_pkg::stage_payload_t stageBus [STAGES+1];
    logic                         fifoInReady;
    logic                         advance;
    logic                         push;
    adc_port_pkg::stage_payload_t lastStage;
    adc_port_pkg::stage_payload_t sampleEntry;

    assign lastStage = stageBus[STAGES];
    // stall only when a finished word cannot enter the buffer
    assign advance = anyEdge && (!lastStage.valid || fifoInReady);
    assign push    = anyEdge && lastStage.valid;

    always_comb begin
        sampleEntry         = '0;
        sampleEntry.valid   = fallEdge && !asleep;
        sampleEntry.residue = adc_port_pkg::RESIDUE_W'(inSync_q);
        sampleEntry.acc     = '0;
    end

    // one driver per element of the stage chain
    assign stageBus[0] = sampleEntry;

    genvar gi;
    generate
        for (gi = 0; gi < STAGES; gi++) begin : g_stage
            conversion_stage u_stage (
                .core_clk (core_clk),
                .rst      (rst),
                .advance  (advance),
                .stageIn  (stageBus[gi]),
                .stageOut (stageBus[gi+1])
            );
        end
    endgenerate

    // ========================================================
    // digital correction to offset binary
    // ========================================================
    function automatic logic [WORD_W-1:0] to_offset_binary(
        input logic signed [adc_port_pkg::ACC_W-1:0] acc
    );
        logic signed [adc_port_pkg::ACC_W:0] scaled;
        // concatenation is unsigned, so re-sign it to keep the shift arithmetic
        scaled = $signed({acc[adc_port_pkg::ACC_W-1], acc}) >>> adc_port_pkg::CORR_SHIFT;
        if (scaled > adc_port_pkg::ACC_HIGH) begin
            to_offset_binary = adc_port_pkg::CODE_TOP;
        end else if (scaled < adc_port_pkg::ACC_LOW) begin
            to_offset_binary = adc_port_pkg::CODE_BOTTOM;
        end else begin
            to_offset_binary = scaled[WORD_W-1:0] ^ adc_port_pkg::CODE_MID;
        end
    endfunction : to_offset_binary

    logic [WORD_W-1:0] correctedWord;
    assign correctedWord = to_offset_binary(lastStage.acc);

    // ========================================================
    // output buffer and latch
    // ========================================================
    logic              fifoOutValid;
    logic              fifoOutReady;
    logic [WORD_W-1:0] fifoOutData;

    // drain stalls while asleep so the last word is held
    assign fifoOutReady = riseEdge && !asleep;

    sample_fifo #(
        .WIDTH (WORD_W),
        .DEPTH (FIFO_D)
    ) u_fifo (
        .core_clk (core_clk),
        .rst      (rst),
        .inValid  (push),
        .inReady  (fifoInReady),
        .inData   (correctedWord),
        .outValid (fifoOutValid),
        .outReady (fifoOutReady),
        .outData  (fifoOutData)
    );

    logic [WORD_W-1:0] word_q;
    logic [WORD_W-1:0] word_d;
    logic              drive_q;
    logic              drive_d;

    always_comb begin
        word_d  = word_q;
        drive_d = !oeSync_q;
        if (fifoOutValid && fifoOutReady) begin
            word_d = fifoOutData;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            word_q  <= adc_port_pkg::CODE_BOTTOM;
            drive_q <= 1'b0;
        end else begin
            word_q  <= word_d;
            drive_q <= drive_d;
        end
    end

    assign sampleWordOut = word_q;
    assign sampleWordOe  = drive_q;

endmodule : pipelined_adc_output_port

/* dv/pipelined_adc_output_port_assertions.sv */
`timescale 1ns/1ps
// ========================================
// port checker
// ========================================
module adc_port_checker #(
    parameter int WORD_W = 10
) (
    // clock and reset
    input wire logic                                     core_clk,
    input wire logic                                     rst,
    // conversion pins
    input wire logic                                     convClk,
    input wire logic signed [adc_port_pkg::ANALOG_W-1:0] heldInput,
    input wire logic                                     sleepRequest,
    input wire logic                                     outEnableN,
    // sample word pins
    input wire logic [WORD_W-1:0]                        sampleWordOut,
    input wire logic                                     sampleWordOe
);
    logic [2:0] upAge_q, upAge_d;
    logic [3:0] riseAge_q, riseAge_d;
    logic       convPrev_q;

    // cycles since reset and since conversion clock rose
    always_comb begin
        upAge_d   = (upAge_q == 3'h7) ? upAge_q : upAge_q + 3'h1;
        riseAge_d = (riseAge_q == 4'hF) ? riseAge_q : riseAge_q + 4'h1;
        if (convClk && !convPrev_q) riseAge_d = 4'h0;
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            upAge_q    <= 3'h0;
            riseAge_q  <= 4'hF;
            convPrev_q <= 1'b0;
        end else begin
            upAge_q    <= upAge_d;
            riseAge_q  <= riseAge_d;
            convPrev_q <= convClk;
        end
    end

    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);

    sequence s_oeHigh; outEnableN [*4]; endsequence
    sequence s_asleep; sleepRequest [*6]; endsequence
    sequence s_convLow; !convClk [*4]; endsequence

    property p_oe_follow; upAge_q > 3'h4 |-> sampleWordOe == !$past(outEnableN, 3); endproperty
    property p_oe_float; s_oeHigh ##0 upAge_q > 3'h4 |-> !sampleWordOe; endproperty
    property p_oe_asleep;
        sleepRequest && upAge_q > 3'h4 && !$past(outEnableN, 3) |-> sampleWordOe;
    endproperty
    property p_sleep_hold; s_asleep |=> $stable(sampleWordOut); endproperty
    property p_change_after_rise; $changed(sampleWordOut) |-> riseAge_q inside {[1:6]}; endproperty
    property p_stable_low; s_convLow |=> $stable(sampleWordOut); endproperty
    property p_one_per_rise; $changed(sampleWordOut) |=> $stable(sampleWordOut) [*5]; endproperty
    property p_reset_out; $fell(rst) |-> sampleWordOut == '0 && !sampleWordOe; endproperty

    a_oe_follow: assert property (p_oe_follow)
        else $error("word enable does not follow its pin");
    a_oe_float: assert property (p_oe_float)
        else $error("word driven while enable pin high");
    a_oe_asleep: assert property (p_oe_asleep)
        else $error("word not driven while asleep with enable low");
    a_sleep_hold: assert property (p_sleep_hold)
        else $error("word changed while asleep");
    a_change_after_rise: assert property (p_change_after_rise)
        else $error("word changed away from a rising edge");
    a_stable_low: assert property (p_stable_low)
        else $error("word changed in low clock phase");
    a_one_per_rise: assert property (p_one_per_rise)
        else $error("word changed twice in one period");
    a_reset_out: assert property (p_reset_out)
        else $error("word pins not quiet out of reset");
endmodule : adc_port_checker

bind pipelined_adc_output_port adc_port_checker #(.WORD_W(WORD_W)) adc_port_checker_i (
    .core_clk(core_clk), .rst(rst), .convClk(convClk), .heldInput(heldInput),
    .sleepRequest(sleepRequest), .outEnableN(outEnableN),
    .sampleWordOut(sampleWordOut), .sampleWordOe(sampleWordOe)
);

/* dv/word_capture_model.sv */
`timescale 1ns/1ps
// ========================================
// receiving capture logic
// ========================================
module word_capture_model #(
    parameter int WORD_W = 10,
    parameter int REFILL = 12
) (
    // pins watched
    input wire logic              convClk,
    input wire logic              sleepRequest,
    input wire logic [WORD_W-1:0] sampleWordOut,
    input wire logic              sampleWordOe,
    // captured result
    output logic [WORD_W-1:0]     capturedWord,
    output logic                  capturedValid
);
    int skip = REFILL;

    initial begin
        capturedWord  = '0;
        capturedValid = 1'b0;
    end

    always @(posedge convClk) begin
        if (sleepRequest || !sampleWordOe) begin
            skip = REFILL;
            capturedValid <= 1'b0;
        end else if (skip > 0) begin
            skip--;
        end else begin
            capturedWord  <= sampleWordOut;
            capturedValid <= 1'b1;
        end
    end
endmodule : word_capture_model

/* dv/pipelined_adc_output_port_bench.sv */
`timescale 1ns/1ps
// ========================================
// bench for the sample word port
// ========================================
module pipelined_adc_output_port_bench;
    logic                                     core_clk;
    logic                                     rst;
    logic                                     convClk;
    logic signed [adc_port_pkg::ANALOG_W-1:0] heldInput;
    logic                                     sleepRequest;
    logic                                     outEnableN;
    logic [adc_port_pkg::WORD_W-1:0]          sampleWordOut;
    logic                                     sampleWordOe;
    logic [adc_port_pkg::WORD_W-1:0]          capturedWord;
    logic                                     capturedValid;
    int n_errors = 0;
    int check_count = 0;
    int q[$];
    int expWord = -1;
    int ends[3] = '{0, -2048, 2047};

    pipelined_adc_output_port pipelined_adc_output_port_i (
        .core_clk(core_clk), .rst(rst), .convClk(convClk), .heldInput(heldInput),
        .sleepRequest(sleepRequest), .outEnableN(outEnableN),
        .sampleWordOut(sampleWordOut), .sampleWordOe(sampleWordOe)
    );

    word_capture_model word_capture_model_i (
        .convClk(convClk), .sleepRequest(sleepRequest), .sampleWordOut(sampleWordOut),
        .sampleWordOe(sampleWordOe), .capturedWord(capturedWord),
        .capturedValid(capturedValid)
    );

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    function automatic int codeOf(input int v);
        return (v + 2048) >> 2;
    endfunction : codeOf

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic summarize();
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : summarize

    // one conversion period, equal phases of 8 core cycles
    task automatic convPeriod(input int v, input bit track);
        logic ok;
        @(posedge core_clk);
        convClk <= 1'b1;
        if (!sleepRequest && q.size() >= 6) expWord = q.pop_front();
        repeat (4) @(posedge core_clk);
        heldInput <= 12'(v);
        repeat (3) @(posedge core_clk);
        ok = (sampleWordOut + 1 >= expWord) && (sampleWordOut <= expWord + 1);
        if (track && expWord >= 0) check({15'h0000, ok}, 16'h0001);
        @(posedge core_clk);
        convClk <= 1'b0;
        if (!sleepRequest) q.push_back(codeOf(v));
        repeat (7) @(posedge core_clk);
    endtask : convPeriod

    task automatic oePulse();
        outEnableN <= 1'b1;
        repeat (5) @(posedge core_clk);
        check({15'h0000, sampleWordOe}, 16'h0000);
        outEnableN <= 1'b0;
        repeat (5) @(posedge core_clk);
        check({15'h0000, sampleWordOe}, 16'h0001);
    endtask : oePulse

    initial begin
        repeat (20000) @(posedge core_clk);
        n_errors++;
        summarize();
    end

    initial begin
        rst = 1'b1;
        convClk = 1'b0;
        heldInput = '0;
        sleepRequest = 1'b0;
        outEnableN = 1'b0;
        void'($urandom(32'h5BE42B03));
        repeat (20) @(posedge core_clk);
        check({6'h00, sampleWordOut}, 16'h0000);
        check({15'h0000, sampleWordOe}, 16'h0000);
        rst <= 1'b0;
        repeat (6) @(posedge core_clk);
        // streaming random samples
        for (int i = 0; i < 40; i++) convPeriod(int'($urandom_range(4095)) - 2048, 1'b1);
        oePulse();
        // power down keeps the last word
        sleepRequest <= 1'b1;
        for (int i = 0; i < 6; i++) convPeriod(int'($urandom_range(4095)) - 2048, 1'b1);
        oePulse();
        sleepRequest <= 1'b0;
        // settle on mid scale and both coding end points
        foreach (ends[k]) begin
            repeat (14) convPeriod(ends[k], 1'b0);
            check({6'h00, sampleWordOut}, 16'(codeOf(ends[k])));
            check({6'h00, capturedWord}, 16'(codeOf(ends[k])));
            check({15'h0000, capturedValid}, 16'h0001);
        end
        summarize();
    end
endmodule : pipelined_adc_output_port_bench
